/* File: inc/tec_map.vh */
// Purpose: Register offsets, field positions and reset values of the timer
// Assumes: AXI4-Lite word-aligned registers, 32-bit data
// Notes:   Definitions only
`ifndef TEC_MAP_VH
`define TEC_MAP_VH

`define TEC_OFF_MODE      8'h00
`define TEC_OFF_PRESC     8'h04
`define TEC_OFF_CTRL      8'h08
`define TEC_OFF_COUNT     8'h0C
`define TEC_OFF_PERIOD    8'h10
`define TEC_OFF_WIDTH     8'h14
`define TEC_OFF_STATUS    8'h18
`define TEC_OFF_IRQ_EN    8'h1C
`define TEC_OFF_IRQ_CLR   8'h20

`define TEC_MODE_STOP     2'h0
`define TEC_MODE_FREE     2'h1
`define TEC_MODE_CLR_TRIG 2'h2
`define TEC_MODE_CLR_PER  2'h3

`define TEC_PM_LO         0
`define TEC_PM_HI         1
`define TEC_ES_LO         4
`define TEC_ES_HI         5

`define TEC_CT_TOG_WID    0
`define TEC_CT_TOG_PER    1
`define TEC_CT_OS_EN      2
`define TEC_CT_OS_TRIG    3
`define TEC_CT_EVENT      4
`define TEC_CT_TOE        5

`define TEC_ST_OVF        0
`define TEC_ST_PER        1
`define TEC_ST_WID        2
`define TEC_ST_CAP        3
`define TEC_NSTAT         4

`define TEC_RST_CMP       16'hFFFF
`define TEC_RESP_OKAY     2'h0
`define TEC_RESP_SLVERR   2'h2

`endif

/* File: hdl/tec_edge.v */
// Purpose: Edge detector with selectable valid edge
// Assumes: Input synchronous to i_clk
// Notes:   Sel 0 falling, 1 rising, 2 none, 3 both
`timescale 1ns/1ns
`include "tec_map.vh"

module tec_edge
(
    input  wire       i_clk,    // System clock
    input  wire       i_rst,    // Sync reset, high
    input  wire       i_pin,    // Pin level
    input  wire [1:0] i_sel,    // Valid edge select
    output wire       o_edge    // One-cycle valid edge pulse
);

    reg prev;   // Pin level one cycle ago

    // Remember last level; reset low so a high pin after reset reads as rising
    always @(posedge i_clk)
    begin
        if (i_rst)
            prev <= 1'b0;
        else
            prev <= i_pin;
    end

    assign o_edge = (i_sel == 2'h0) ? (prev & ~i_pin) :
                    (i_sel == 2'h1) ? (~prev & i_pin) :
                    (i_sel == 2'h3) ? (prev ^ i_pin) : 1'b0;

endmodule

/* File: hdl/tec_timer.v */
// Purpose: 16-bit timer/event counter with period and width compares
// Assumes: AXI4-Lite slave on i_clk; pins synchronous to i_clk
// Notes:   Count clock is i_clk or the event pin; prescaler not modelled
// Function
// - Period is compare plus one clocks
// - Event count readable from count register
// - Trigger pin restarts counter in one-shot
// - Nonzero mode field starts counting immediately
// - First match may shift one count clock
// - Soft trigger self-clears, reads zero
// - Edge select at prescaler bits 4,5
// - Overflow flag on FFFF to 0000 wrap
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tec_map.vh"

module tec_timer
(
    input  wire        i_clk,                 // 20 MHz system clock
    input  wire        i_rst,                 // Sync reset, high
    input  wire        s_axi_awvalid,         // Write address valid
    output wire        s_axi_awready,         // Write address ready
    input  wire [7:0]  s_axi_awaddr,          // Write byte address
    input  wire        s_axi_wvalid,          // Write data valid
    output wire        s_axi_wready,          // Write data ready
    input  wire [31:0] s_axi_wdata,           // Write data
    input  wire [3:0]  s_axi_wstrb,           // Write byte strobes
    output reg         s_axi_bvalid,          // Write response valid
    input  wire        s_axi_bready,          // Write response ready
    output reg  [1:0]  s_axi_bresp,           // Write response
    input  wire        s_axi_arvalid,         // Read address valid
    output wire        s_axi_arready,         // Read address ready
    input  wire [7:0]  s_axi_araddr,          // Read byte address
    output reg         s_axi_rvalid,          // Read data valid
    input  wire        s_axi_rready,          // Read data ready
    output reg  [31:0] s_axi_rdata,           // Read data
    output reg  [1:0]  s_axi_rresp,           // Read response
    input  wire        i_trigger_capture_pin0,// Trigger / capture / event pin
    input  wire        i_capture_pin1,        // Second capture pin
    output reg         o_timer_out,           // Timer output pin level
    output wire        o_irq                  // Level interrupt
);

    reg  [1:0]  op_mode;              // Operating mode field
    reg  [7:0]  prescaler_mode_reg;   // Edge selects live here
    reg  [5:0]  ctrl;                 // Output and one-shot control
    reg  [15:0] timer_count_reg;      // The counter
    reg  [15:0] period_compare_reg;   // Period compare / capture 0
    reg  [15:0] width_compare_reg;    // Width compare / capture 1
    reg  [`TEC_NSTAT-1:0] status;     // Sticky event flags
    reg  [`TEC_NSTAT-1:0] irq_en;     // Interrupt enables
    reg         os_active;            // One-shot pulse in progress
    reg         aw_held;              // Write address captured
    reg         w_held;               // Write data captured
    reg  [7:0]  aw_addr;              // Captured write address
    reg  [31:0] w_data;               // Captured write data
    reg  [3:0]  w_strb;               // Captured strobes

    wire        trig_edge;            // Valid edge on pin0
    wire        cap1_edge;            // Valid edge on pin1
    wire        cnt_tick;             // Count clock this cycle
    wire        wr_go;                // Register write happens
    wire        running;              // Mode not stop
    wire        oneshot_soft;         // Soft trigger write
    wire        per_match;            // Counter equals period
    wire        wid_match;            // Counter equals width
    wire        restart;              // Clear and start counter
    reg  [`TEC_NSTAT-1:0] next_status;// Flag next state
    reg  [31:0] rd_word;              // Read mux

    // Trigger edge chosen by prescaler bits 4,5
    tec_edge u_trig
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_pin  (i_trigger_capture_pin0),
        .i_sel  (prescaler_mode_reg[`TEC_ES_HI:`TEC_ES_LO]),
        .o_edge (trig_edge)
    );

    // Capture pin 1 uses bits 6,7 of the same register
    tec_edge u_cap1
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_pin  (i_capture_pin1),
        .i_sel  (prescaler_mode_reg[7:6]),
        .o_edge (cap1_edge)
    );

    // Bus handshake: address and data accepted independently
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go         = aw_held & w_held & ~s_axi_bvalid;

    assign running      = (op_mode != `TEC_MODE_STOP);
    // Event mode counts pin edges, so the count register holds events
    assign cnt_tick     = running & (ctrl[`TEC_CT_EVENT] ? trig_edge : 1'b1);
    assign oneshot_soft = wr_go & (aw_addr == `TEC_OFF_CTRL) & w_strb[0]
                          & w_data[`TEC_CT_OS_TRIG] & ctrl[`TEC_CT_OS_EN];
    assign per_match    = running & (timer_count_reg == period_compare_reg);
    assign wid_match    = running & (timer_count_reg == width_compare_reg);
    // Pin trigger stays live even in soft one-shot: it can fire a stray pulse
    assign restart      = (op_mode == `TEC_MODE_CLR_TRIG) & ~ctrl[`TEC_CT_EVENT]
                          & (trig_edge | oneshot_soft);

    // Write channel capture and response
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TEC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped or misaligned offsets answer with an error
                s_axi_bresp  <= (aw_addr[1:0] != 2'h0 || aw_addr > `TEC_OFF_IRQ_CLR)
                                ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes plus captures; bus writes to the compare registers win
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            op_mode            <= `TEC_MODE_STOP;
            prescaler_mode_reg <= 8'h00;
            ctrl               <= 6'h00;
            period_compare_reg <= `TEC_RST_CMP;
            width_compare_reg  <= `TEC_RST_CMP;
            irq_en             <= {`TEC_NSTAT{1'b0}};
        end
        else
        begin
            if (wr_go && w_strb[0])
            begin
                case (aw_addr)
                    `TEC_OFF_MODE   : op_mode <= w_data[`TEC_PM_HI:`TEC_PM_LO];
                    `TEC_OFF_PRESC  : prescaler_mode_reg <= w_data[7:0];
                    // Trigger bit never stored, so it reads zero
                    `TEC_OFF_CTRL   : ctrl <= w_data[5:0] & 6'h37;
                    `TEC_OFF_IRQ_EN : irq_en <= w_data[`TEC_NSTAT-1:0];
                    default         : ;
                endcase
            end
            // Compare writes take effect next cycle; no shadow buffering,
            // hence the safe width-update sequence software must follow
            if (wr_go && aw_addr == `TEC_OFF_PERIOD && w_strb[1:0] == 2'h3)
                period_compare_reg <= w_data[15:0];
            else if (running && ~ctrl[`TEC_CT_EVENT] && trig_edge
                     && op_mode == `TEC_MODE_FREE)
                period_compare_reg <= timer_count_reg;   // Capture on pin0
            if (wr_go && aw_addr == `TEC_OFF_WIDTH && w_strb[1:0] == 2'h3)
                width_compare_reg <= w_data[15:0];
            else if (running && cap1_edge && op_mode == `TEC_MODE_FREE
                     && ~ctrl[`TEC_CT_TOG_WID])
                width_compare_reg <= timer_count_reg;    // Capture on pin1
        end
    end

    // Counter: starts on the cycle after the mode write; starts are not
    // aligned to any count-clock phase, so first match can shift a tick
    always @(posedge i_clk)
    begin
        if (i_rst)
            timer_count_reg <= 16'h0000;
        else if (wr_go && aw_addr == `TEC_OFF_MODE && w_data[1:0] == `TEC_MODE_STOP)
            timer_count_reg <= 16'h0000;
        else if (restart)
            timer_count_reg <= 16'h0000;
        else if (cnt_tick)
        begin
            // Period match clears: period is compare plus one ticks
            if (op_mode == `TEC_MODE_CLR_PER && per_match)
                timer_count_reg <= 16'h0000;
            else
                timer_count_reg <= timer_count_reg + 16'h0001;
        end
    end

    // One-shot tracking and output flip-flop
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            os_active   <= 1'b0;
            o_timer_out <= 1'b0;
        end
        else if (~ctrl[`TEC_CT_TOE])
        begin
            os_active   <= 1'b0;
            o_timer_out <= 1'b0;
        end
        else if (restart && ctrl[`TEC_CT_OS_EN])
        begin
            os_active   <= 1'b1;
            o_timer_out <= 1'b0;
        end
        else if (cnt_tick)
        begin
            if (ctrl[`TEC_CT_OS_EN])
            begin
                // Pulse rises at width match, ends at period match
                if (os_active && wid_match)
                    o_timer_out <= 1'b1;
                if (os_active && per_match)
                begin
                    o_timer_out <= 1'b0;
                    os_active   <= 1'b0;
                end
            end
            else if (wid_match && ctrl[`TEC_CT_TOG_WID])
                o_timer_out <= ~o_timer_out;
            else if (per_match && ctrl[`TEC_CT_TOG_PER])
                o_timer_out <= ~o_timer_out;
        end
    end

    // Sticky flags: hardware set wins over software clear
    always @*
    begin
        next_status = status;
        if (wr_go && aw_addr == `TEC_OFF_IRQ_CLR && w_strb[0])
            next_status = status & ~w_data[`TEC_NSTAT-1:0];
        if (cnt_tick && timer_count_reg == 16'hFFFF
            && !(op_mode == `TEC_MODE_CLR_PER && per_match && period_compare_reg != 16'hFFFF))
            next_status[`TEC_ST_OVF] = 1'b1;
        if (cnt_tick && per_match)
            next_status[`TEC_ST_PER] = 1'b1;
        if (cnt_tick && wid_match && ctrl[`TEC_CT_TOG_WID])
            next_status[`TEC_ST_WID] = 1'b1;
        if (running && (trig_edge | cap1_edge) && op_mode == `TEC_MODE_FREE)
            next_status[`TEC_ST_CAP] = 1'b1;
    end

    always @(posedge i_clk)
    begin
        if (i_rst)
            status <= {`TEC_NSTAT{1'b0}};
        else
            status <= next_status;
    end

    assign o_irq = |(status & irq_en);

    // Read data mux
    always @*
    begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `TEC_OFF_MODE   : rd_word = {30'h0000_0000, op_mode};
            `TEC_OFF_PRESC  : rd_word = {24'h00_0000, prescaler_mode_reg};
            `TEC_OFF_CTRL   : rd_word = {26'h000_0000, ctrl};
            `TEC_OFF_COUNT  : rd_word = {16'h0000, timer_count_reg};
            `TEC_OFF_PERIOD : rd_word = {16'h0000, period_compare_reg};
            `TEC_OFF_WIDTH  : rd_word = {16'h0000, width_compare_reg};
            `TEC_OFF_STATUS : rd_word = {28'h000_0000, status};
            `TEC_OFF_IRQ_EN : rd_word = {28'h000_0000, irq_en};
            default         : rd_word = 32'h0000_0000;
        endcase
    end

    // Read response registered one cycle after address
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TEC_RESP_OKAY;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > `TEC_OFF_IRQ_CLR)
                            ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

/* File: tb/tec_timer_asserts.sv */
// Purpose: Bus and pin checks on the timer top ports
// Assumes: One clock domain, sync reset high
// Notes:   Bound from the bench top file
`timescale 1ns/1ns
`include "tec_map.vh"

module tec_timer_asserts
(
    input logic        i_clk,         // Clock
    input logic        i_rst,         // Reset
    input logic        s_axi_awvalid, // AW valid
    input logic        s_axi_awready, // AW ready
    input logic [7:0]  s_axi_awaddr,  // AW address
    input logic        s_axi_wvalid,  // W valid
    input logic        s_axi_wready,  // W ready
    input logic        s_axi_bvalid,  // B valid
    input logic        s_axi_bready,  // B ready
    input logic [1:0]  s_axi_bresp,   // B response
    input logic        s_axi_arvalid, // AR valid
    input logic        s_axi_arready, // AR ready
    input logic [7:0]  s_axi_araddr,  // AR address
    input logic        s_axi_rvalid,  // R valid
    input logic        s_axi_rready,  // R ready
    input logic [31:0] s_axi_rdata,   // R data
    input logic        o_timer_out,   // Timer pin
    input logic        o_irq          // Interrupt
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Both write channels taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    property p_wr_ans;
        s_wr_both |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_wr_bad;
        s_wr_both ##0 (s_axi_awaddr > 8'h20) |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2);
    endproperty
    property p_rd_ans;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    // Soft trigger must never be seen set
    property p_rd_ctrl;
        s_rd_take ##0 (s_axi_araddr == `TEC_OFF_CTRL) |=> !s_axi_rdata[`TEC_CT_OS_TRIG];
    endproperty
    // Count is 16 bits, upper bits read zero
    property p_rd_count;
        s_rd_take ##0 (s_axi_araddr == `TEC_OFF_COUNT) |=> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    // No new write while a write answer waits, no new read while a read answer waits
    property p_busy_block;
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    // Everything quiet at the first edge after reset
    property p_rst_quiet;
        $fell(i_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !o_timer_out && !o_irq;
    endproperty

    a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
    a_wr_bad: assert property (p_wr_bad) else $error("unmapped write not refused");
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("soft trigger read as one");
    a_rd_count: assert property (p_rd_count) else $error("count upper bits set");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_busy_block: assert property (p_busy_block) else $error("ready while answer waits");
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench driving the timer over its register bus
// Assumes: Count clock is i_clk, pin0 edges in the event counting test; pins driven synchronously
// Notes:   Overflow run takes about 66k cycles
`timescale 1ns/1ns
`include "tec_map.vh"

module testbench;
    logic        i_clk;                    // 20 MHz clock
    logic        i_rst;                    // Sync reset
    logic        awv, wv, bry, arv, rry;   // Master valids and readies
    logic [7:0]  awa, ara;                 // Addresses
    logic [31:0] wd, d;                    // Write data, read result
    logic [1:0]  rsp;                      // Write response
    logic [1:0]  rrsp;                     // Read response of the last read
    logic        pin0, pin1;               // Timer pins
    wire         awr, wrdy, bv, arr, rv;   // Slave handshakes
    wire         tout, irq;                // Timer pin, interrupt
    wire  [1:0]  br, rr;                   // Responses
    wire  [31:0] rdat;                     // Read data
    int          mismatches, num_checks;   // Tallies
    int          k, a, b;                  // Scratch

    tec_timer i_dut
    (
        .i_clk(i_clk), .i_rst(i_rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .i_trigger_capture_pin0(pin0), .i_capture_pin1(pin1), .o_timer_out(tout), .o_irq(irq)
    );

    // 50 ns clock
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Compare and tally
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Write; handshakes judged at the negedge before the sampling edge
    task automatic bus_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
        int   n;
        logic ah, wh, bh;
        n = 0;
        bh = 1'b0;
        @(posedge i_clk);
        awv <= 1'b1;
        wv  <= 1'b1;
        awa <= ad;
        wd  <= dt;
        bry <= 1'b1;
        while (!bh && n < 50)
        begin
            @(negedge i_clk);
            ah = awv && awr;
            wh = wv && wrdy;
            bh = bv;
            r  = br;
            n++;
            @(posedge i_clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end
        bry <= 1'b0;
        if (!bh) chk("write answer", 0, 1);
    endtask

    // Read; data taken at the edge where rvalid is sampled
    task automatic bus_rd(input logic [7:0] ad, output logic [31:0] dt);
        int   n;
        logic ah, rh;
        n = 0;
        rh = 1'b0;
        ah = 1'b0;
        @(posedge i_clk);
        arv <= 1'b1;
        ara <= ad;
        rry <= 1'b1;
        // Address held until the edge that takes it, released only after it
        while (!rh && n < 50)
        begin
            @(negedge i_clk);
            ah = arv && arr;
            rh = rv;
            dt = rdat;
            rrsp = rr;
            n++;
            @(posedge i_clk);
            if (ah) arv <= 1'b0;
        end
        rry <= 1'b0;
        if (!rh) chk("read answer", 0, 1);
    endtask

    // Cycles until the timer pin changes, bounded
    task automatic span(output int n);
        logic v;
        v = tout;
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (tout === v && n < 200);
    endtask

    // Pulses on pin0, three cycles high, four low
    task automatic pulses(input int cnt);
        repeat (cnt)
        begin
            @(posedge i_clk);
            pin0 <= 1'b1;
            repeat (3) @(posedge i_clk);
            pin0 <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask

    // Single exit for normal end and hang
    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog well past the overflow run
    initial
    begin
        repeat (80000) @(posedge i_clk);
        mismatches++;
        stop_test;
    end

    // Main sequence
    initial
    begin
        {i_rst, awv, wv, bry, arv, rry, pin0, pin1} = 8'h80;
        {awa, ara, wd} = 48'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values, then one unmapped read that must be refused
        for (k = 0; k < 10; k++)
        begin
            bus_rd(8'(k * 4), d);
            chk("reset value", d, (k == 4 || k == 5) ? 32'h0000FFFF : 32'h0);
            chk("read resp", rrsp, (k == 9) ? `TEC_RESP_SLVERR : `TEC_RESP_OKAY);
        end
        bus_wr(8'h24, 32'h1, rsp);
        chk("unmapped write", rsp, `TEC_RESP_SLVERR);
        // Pulse generator, period 9, width 3
        bus_wr(`TEC_OFF_PERIOD, 32'h9, rsp);
        bus_wr(`TEC_OFF_WIDTH, 32'h3, rsp);
        bus_wr(`TEC_OFF_CTRL, 32'h23, rsp);
        bus_wr(`TEC_OFF_MODE, 32'h3, rsp);
        @(negedge i_clk);
        span(a);
        span(a);
        span(b);
        chk("ppg period", a + b, 10);
        chk("ppg width", a == 4 || b == 4, 1);
        // Width rewrite while running, safe order
        bus_wr(`TEC_OFF_CTRL, 32'h22, rsp);
        bus_wr(`TEC_OFF_IRQ_EN, 32'h0, rsp);
        bus_wr(`TEC_OFF_WIDTH, 32'h5, rsp);
        @(posedge i_clk);
        bus_wr(`TEC_OFF_CTRL, 32'h23, rsp);
        bus_wr(`TEC_OFF_IRQ_CLR, 32'h4, rsp);
        @(negedge i_clk);
        chk("irq masked", irq, 0);
        bus_wr(`TEC_OFF_IRQ_EN, 32'h4, rsp);
        @(negedge i_clk);
        span(a);
        span(a);
        span(b);
        chk("new width", a == 6 || b == 6, 1);
        chk("new period", a + b, 10);
        chk("width irq", irq, 1);
        bus_rd(`TEC_OFF_STATUS, d);
        chk("width flag", d[`TEC_ST_WID], 1);
        bus_wr(`TEC_OFF_MODE, 32'h0, rsp);
        bus_wr(`TEC_OFF_IRQ_CLR, 32'hF, rsp);
        @(negedge i_clk);
        chk("irq cleared", irq, 0);
        // One-shot, soft trigger then pin trigger
        bus_wr(`TEC_OFF_PRESC, 32'h10, rsp);
        bus_wr(`TEC_OFF_PERIOD, 32'h14, rsp);
        bus_wr(`TEC_OFF_WIDTH, 32'h5, rsp);
        bus_wr(`TEC_OFF_CTRL, 32'h24, rsp);
        bus_wr(`TEC_OFF_MODE, 32'h2, rsp);
        repeat (30) @(posedge i_clk);
        bus_wr(`TEC_OFF_CTRL, 32'h2C, rsp);
        @(negedge i_clk);
        span(a);
        span(b);
        chk("oneshot rise", a <= 8, 1);
        chk("oneshot high", b, 15);
        bus_rd(`TEC_OFF_CTRL, d);
        chk("trigger reads zero", d, 32'h24);
        @(posedge i_clk);
        pin0 <= 1'b1;
        @(negedge i_clk);
        span(a);
        chk("pin restart", a <= 8 && tout === 1'b1, 1);
        span(b);
        @(posedge i_clk);
        pin0 <= 1'b0;
        // Event counting for every edge select code
        for (k = 0; k < 4; k++)
        begin
            bus_wr(`TEC_OFF_MODE, 32'h0, rsp);
            bus_wr(`TEC_OFF_PRESC, 32'(k << 4), rsp);
            bus_wr(`TEC_OFF_CTRL, 32'h10, rsp);
            bus_wr(`TEC_OFF_MODE, 32'h1, rsp);
            pulses(5);
            bus_rd(`TEC_OFF_COUNT, d);
            chk("event count", d, k == 3 ? 10 : (k == 2 ? 0 : 5));
        end
        // Free run from stop, then full wrap
        bus_wr(`TEC_OFF_MODE, 32'h0, rsp);
        bus_wr(`TEC_OFF_CTRL, 32'h0, rsp);
        bus_wr(`TEC_OFF_IRQ_CLR, 32'hF, rsp);
        bus_wr(`TEC_OFF_MODE, 32'h1, rsp);
        bus_rd(`TEC_OFF_COUNT, d);
        chk("count started", d > 0 && d < 8, 1);
        // Width measurement: pin0 rise captures start, pin1 fall the end
        @(posedge i_clk);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        repeat (7) @(posedge i_clk);
        pin1 <= 1'b0;
        repeat (3) @(posedge i_clk);
        bus_rd(`TEC_OFF_PERIOD, d);
        a = d;
        bus_rd(`TEC_OFF_WIDTH, d);
        chk("capture span", d - a, 7);
        repeat (65536) @(posedge i_clk);
        bus_rd(`TEC_OFF_STATUS, d);
        chk("overflow flag", d[`TEC_ST_OVF], 1);
        stop_test;
    end
endmodule

bind tec_timer tec_timer_asserts i_chk
(
    .i_clk(i_clk), .i_rst(i_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .o_timer_out(o_timer_out), .o_irq(o_irq)
);
